// file: hw/bsp_pkg.sv
// Shared constants for the burst-of-two double data rate SRAM port
package bsp_pkg;
  // Array and bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 36;
  localparam int LANES = 4;
  localparam int BYTE_W = 9;
  localparam int DEPTH = 2 ** ADDR_W;
  // Clocking of the link
  localparam int CLK_PERIOD_NS = 4;
  localparam int K_PERIOD_NS = 80;
  localparam int K_HALF_CYC = K_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int K_MID_CYC = K_HALF_CYC / 2;
  localparam int CNT_W = 8;
  // Read latency in link half cycles, DLL on and off
  localparam int LAT_DLL_EDGES = 5;
  localparam int LAT_NODLL_EDGES = 2;
  localparam int PIPE_LEN = LAT_DLL_EDGES + 2;
  // Write buffer entries ahead of the array
  localparam int WB_DEPTH = 2;
  // Output impedance calibration
  localparam int IMP_W = 4;
  localparam logic [IMP_W-1:0] IMP_MID = 4'h8;
  localparam int CAL_LIMIT_KCYC = 1024;
  localparam int CAL_STEP_KCYC = CAL_LIMIT_KCYC / (2 ** (IMP_W - 1));
  localparam int KCNT_W = 10;
endpackage : bsp_pkg

// file: hw/bsp_link_if.sv
// Pin bundle between the memory controller and the SRAM port
`timescale 1ns/100ps
interface bsp_link_if;
  logic k;
  logic k_n;
  logic read_n;
  logic write_n;
  logic doff_n;
  logic [bsp_pkg::ADDR_W-1:0] sync_addr_in;
  logic [bsp_pkg::DATA_W-1:0] write_data_in;
  logic [bsp_pkg::LANES-1:0] byte_lane_write_n;
  logic [bsp_pkg::DATA_W-1:0] read_data_out;
  logic read_data_oe;
  logic echo_timing_out;
  logic echo_timing_out_bar;
  logic read_valid_flag;

  modport dev (
    input k, k_n, read_n, write_n, doff_n, sync_addr_in, write_data_in,
    input byte_lane_write_n,
    output read_data_out, read_data_oe, echo_timing_out,
    output echo_timing_out_bar, read_valid_flag
  );
  modport host (
    output k, k_n, read_n, write_n, doff_n, sync_addr_in, write_data_in,
    output byte_lane_write_n,
    input read_data_out, read_data_oe, echo_timing_out,
    input echo_timing_out_bar, read_valid_flag
  );
endinterface : bsp_link_if

// file: hw/bsp_dev.sv
// SRAM end: burst-of-two DDR memory with write buffer and echo clocks
`timescale 1ns/100ps
module bsp_dev (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  bsp_link_if.dev lnk,
  input wire logic [bsp_pkg::IMP_W-1:0] impedance_ref_pin,
  output logic [bsp_pkg::IMP_W-1:0] drive_imp_code
);
  localparam int AW = bsp_pkg::ADDR_W;
  localparam int DW = bsp_pkg::DATA_W;
  localparam int LW = bsp_pkg::LANES;
  localparam int IN_W = 4 + AW + DW + LW;
  localparam logic [IN_W-1:0] IN_IDLE = {4'h7, {(IN_W - 4){1'b0}}};

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [LW-1:0] keep_n
  );
    logic [DW-1:0] r;
    r = old_w;
    for (int i = 0; i < LW; i++) begin
      if (!keep_n[i]) begin
        r[i*bsp_pkg::BYTE_W +: bsp_pkg::BYTE_W] =
          new_w[i*bsp_pkg::BYTE_W +: bsp_pkg::BYTE_W];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [AW-1:0] addr_next(input logic [AW-1:0] a);
    return a + 1'b1;
  endfunction : addr_next

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, three stages
  logic [IN_W-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= IN_IDLE;
      s2_q <= IN_IDLE;
      s3_q <= IN_IDLE;
    end else if (ce) begin
      s1_q <= {lnk.k, lnk.read_n, lnk.write_n, lnk.doff_n, lnk.sync_addr_in,
               lnk.write_data_in, lnk.byte_lane_write_n};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic k_s2, k_s3, rn_s3, wn_s3, doff_s3;
  logic [AW-1:0] addr_s3;
  logic [DW-1:0] data_s3;
  logic [LW-1:0] be_s3;
  assign k_s2 = s2_q[IN_W-1];
  assign {k_s3, rn_s3, wn_s3, doff_s3, addr_s3, data_s3, be_s3} = s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Link clock edge finder
  logic k_lvl_q, k_lvl_d, rise, fall, edg;

  always_comb begin
    k_lvl_d = k_lvl_q;
    rise = 1'b0;
    fall = 1'b0;
    if (k_s2 == k_s3 && k_s3 != k_lvl_q) begin
      k_lvl_d = k_s3;
      rise = k_s3;
      fall = !k_s3;
    end
  end
  assign edg = rise | fall;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      k_lvl_q <= 1'b0;
    end else if (ce) begin
      k_lvl_q <= k_lvl_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write port: capture, buffer and commit
  logic [DW-1:0] mem_q [bsp_pkg::DEPTH];
  logic half_q, half_d;
  logic [DW-1:0] wd0_q, wd0_d;
  logic [LW-1:0] wm0_q, wm0_d;
  logic wv_q [bsp_pkg::WB_DEPTH], wv_d [bsp_pkg::WB_DEPTH];
  logic [AW-1:0] wa_q [bsp_pkg::WB_DEPTH], wa_d [bsp_pkg::WB_DEPTH];
  logic [DW-1:0] w0_q [bsp_pkg::WB_DEPTH], w0_d [bsp_pkg::WB_DEPTH];
  logic [DW-1:0] w1_q [bsp_pkg::WB_DEPTH], w1_d [bsp_pkg::WB_DEPTH];
  logic [LW-1:0] m0_q [bsp_pkg::WB_DEPTH], m0_d [bsp_pkg::WB_DEPTH];
  logic [LW-1:0] m1_q [bsp_pkg::WB_DEPTH], m1_d [bsp_pkg::WB_DEPTH];
  logic commit;
  localparam int OLD = bsp_pkg::WB_DEPTH - 1;

  always_comb begin
    half_d = half_q;
    wd0_d = wd0_q;
    wm0_d = wm0_q;
    wv_d = wv_q;
    wa_d = wa_q;
    w0_d = w0_q;
    w1_d = w1_q;
    m0_d = m0_q;
    m1_d = m1_q;
    commit = 1'b0;
    if (rise) begin
      half_d = !wn_s3;
      wd0_d = data_s3;
      wm0_d = be_s3;
    end else if (fall && half_q) begin
      half_d = 1'b0;
      commit = wv_q[OLD];
      for (int i = OLD; i > 0; i--) begin
        wv_d[i] = wv_q[i-1];
        wa_d[i] = wa_q[i-1];
        w0_d[i] = w0_q[i-1];
        w1_d[i] = w1_q[i-1];
        m0_d[i] = m0_q[i-1];
        m1_d[i] = m1_q[i-1];
      end
      wv_d[0] = 1'b1;
      wa_d[0] = addr_s3;
      w0_d[0] = wd0_q;
      m0_d[0] = wm0_q;
      w1_d[0] = data_s3;
      m1_d[0] = be_s3;
    end
  end

  // Buffer and capture registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      half_q <= 1'b0;
      wd0_q <= '0;
      wm0_q <= '1;
      for (int i = 0; i < bsp_pkg::WB_DEPTH; i++) begin
        wv_q[i] <= 1'b0;
        wa_q[i] <= '0;
        w0_q[i] <= '0;
        w1_q[i] <= '0;
        m0_q[i] <= '1;
        m1_q[i] <= '1;
      end
    end else if (ce) begin
      half_q <= half_d;
      wd0_q <= wd0_d;
      wm0_q <= wm0_d;
      wv_q <= wv_d;
      wa_q <= wa_d;
      w0_q <= w0_d;
      w1_q <= w1_d;
      m0_q <= m0_d;
      m1_q <= m1_d;
    end
  end

  // Array commit of the oldest buffered burst
  always_ff @(posedge ref_clk) begin
    if (ce && commit) begin
      mem_q[wa_q[OLD]] <= merge(mem_q[wa_q[OLD]], w0_q[OLD], m0_q[OLD]);
      mem_q[addr_next(wa_q[OLD])] <=
        merge(mem_q[addr_next(wa_q[OLD])], w1_q[OLD], m1_q[OLD]);
    end
  end

  // Coherent word lookup: array, then buffer from oldest to newest
  function automatic logic [DW-1:0] fetch(input logic [AW-1:0] a);
    logic [DW-1:0] r;
    r = mem_q[a];
    for (int i = OLD; i >= 0; i--) begin
      if (wv_q[i] && wa_q[i] == a) begin
        r = merge(r, w0_q[i], m0_q[i]);
      end
      if (wv_q[i] && addr_next(wa_q[i]) == a) begin
        r = merge(r, w1_q[i], m1_q[i]);
      end
    end
    return r;
  endfunction : fetch

  ////////////////////////////////////////////////////////////////////////
  // Read port: latency pipe, output words, echo clocks, valid flag
  localparam int PIPE_W = bsp_pkg::PIPE_LEN;
  logic [PIPE_W-1:0] rp_q, rp_d;
  logic [AW-1:0] ra_q [PIPE_W], ra_d [PIPE_W];
  logic [DW-1:0] q_q, q_d;
  logic oe_q, oe_d, vld_q, vld_d, echo_q, echo_d;
  int lat;

  always_comb begin
    rp_d = rp_q;
    ra_d = ra_q;
    q_d = q_q;
    oe_d = oe_q;
    vld_d = vld_q;
    echo_d = echo_q;
    lat = doff_s3 ? bsp_pkg::LAT_DLL_EDGES : bsp_pkg::LAT_NODLL_EDGES;
    if (edg) begin
      // Pipe shifts on every edge, so idle cycles never stop it
      rp_d = {rp_q[PIPE_W-2:0], rise && !rn_s3};
      ra_d[0] = addr_s3;
      for (int i = 1; i < PIPE_W; i++) begin
        ra_d[i] = ra_q[i-1];
      end
      echo_d = k_lvl_d;
      vld_d = rp_d[lat-1];
      oe_d = 1'b0;
      if (rp_d[lat]) begin
        q_d = fetch(ra_d[lat]);
        oe_d = 1'b1;
      end else if (rp_d[lat+1]) begin
        q_d = fetch(addr_next(ra_d[lat+1]));
        oe_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rp_q <= '0;
      for (int i = 0; i < PIPE_W; i++) begin
        ra_q[i] <= '0;
      end
      q_q <= '0;
      oe_q <= 1'b0;
      vld_q <= 1'b0;
      echo_q <= 1'b0;
    end else if (ce) begin
      rp_q <= rp_d;
      ra_q <= ra_d;
      q_q <= q_d;
      oe_q <= oe_d;
      vld_q <= vld_d;
      echo_q <= echo_d;
    end
  end

  assign lnk.read_data_out = q_q;
  assign lnk.read_data_oe = oe_q;
  assign lnk.echo_timing_out = echo_q;
  assign lnk.echo_timing_out_bar = !echo_q;
  assign lnk.read_valid_flag = vld_q;

  ////////////////////////////////////////////////////////////////////////
  // Output impedance: start mid-range, step toward the reference
  logic [bsp_pkg::KCNT_W-1:0] kc_q, kc_d;
  logic [bsp_pkg::IMP_W-1:0] imp_q, imp_d;

  always_comb begin
    kc_d = kc_q;
    imp_d = imp_q;
    if (rise) begin
      kc_d = kc_q + 1'b1;
      if (kc_q == bsp_pkg::KCNT_W'(bsp_pkg::CAL_STEP_KCYC - 1)) begin
        kc_d = '0;
        if (imp_q < impedance_ref_pin) begin
          imp_d = imp_q + 1'b1;
        end else if (imp_q > impedance_ref_pin) begin
          imp_d = imp_q - 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      kc_q <= '0;
      imp_q <= bsp_pkg::IMP_MID;
    end else if (ce) begin
      kc_q <= kc_d;
      imp_q <= imp_d;
    end
  end

  assign drive_imp_code = imp_q;
endmodule : bsp_dev

// file: hw/bsp_host.sv
// Controller end: makes the link clock, issues bursts, captures read data
`timescale 1ns/100ps
module bsp_host (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  bsp_link_if.host lnk,
  input wire logic dll_on,
  input wire logic rd_req,
  input wire logic [bsp_pkg::ADDR_W-1:0] rd_addr,
  output logic rd_ready,
  input wire logic wr_req,
  input wire logic [bsp_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [bsp_pkg::DATA_W-1:0] wr_word0,
  input wire logic [bsp_pkg::LANES-1:0] wr_lane0_n,
  input wire logic [bsp_pkg::DATA_W-1:0] wr_word1,
  input wire logic [bsp_pkg::LANES-1:0] wr_lane1_n,
  output logic wr_ready,
  output logic rd_done,
  output logic [bsp_pkg::DATA_W-1:0] rd_word0,
  output logic [bsp_pkg::DATA_W-1:0] rd_word1
);
  localparam int AW = bsp_pkg::ADDR_W;
  localparam int DW = bsp_pkg::DATA_W;
  localparam int LW = bsp_pkg::LANES;
  localparam int CW = bsp_pkg::CNT_W;

  ////////////////////////////////////////////////////////////////////////
  // Clock divider and command launch, mid-phase of K
  logic [CW-1:0] cnt_q, cnt_d;
  logic k_q, k_d, rn_q, rn_d, wn_q, wn_d, doff_q;
  logic [AW-1:0] a_q, a_d, ra_q, ra_d, wa_q, wa_d;
  logic [DW-1:0] d_q, d_d, w0_q, w0_d, w1_q, w1_d;
  logic [LW-1:0] be_q, be_d, m0_q, m0_d, m1_q, m1_d;
  logic rp_q, rp_d, wp_q, wp_d, gap_q, gap_d, wgo_q, wgo_d, mid;

  always_comb begin
    cnt_d = cnt_q + 1'b1;
    k_d = k_q;
    {rn_d, wn_d, a_d, d_d, be_d} = {rn_q, wn_q, a_q, d_q, be_q};
    {rp_d, wp_d, gap_d, wgo_d} = {rp_q, wp_q, gap_q, wgo_q};
    {ra_d, wa_d, w0_d, w1_d, m0_d, m1_d} =
      {ra_q, wa_q, w0_q, w1_q, m0_q, m1_q};
    if (cnt_q == CW'(bsp_pkg::K_HALF_CYC - 1)) begin
      cnt_d = '0;
      k_d = !k_q;
    end
    mid = cnt_q == CW'(bsp_pkg::K_MID_CYC);
    if (mid && !k_q) begin
      // Set up the commands sampled at the coming K rise
      rn_d = 1'b1;
      gap_d = 1'b0;
      if (rp_q && !gap_q) begin
        rn_d = 1'b0;
        a_d = ra_q;
        rp_d = 1'b0;
        gap_d = 1'b1;
      end
      wn_d = !wp_q;
      wgo_d = wp_q;
      if (wp_q) begin
        d_d = w0_q;
        be_d = m0_q;
      end
    end else if (mid && k_q) begin
      // Set up what the coming K# rise samples
      rn_d = 1'b1;
      wn_d = 1'b1;
      if (wgo_q) begin
        a_d = wa_q;
        d_d = w1_q;
        be_d = m1_q;
        wp_d = 1'b0;
        wgo_d = 1'b0;
      end
    end
    if (rd_req && !rp_q) begin
      rp_d = 1'b1;
      ra_d = rd_addr;
    end
    if (wr_req && !wp_q) begin
      {wp_d, wa_d, w0_d, m0_d, w1_d, m1_d} =
        {1'b1, wr_addr, wr_word0, wr_lane0_n, wr_word1, wr_lane1_n};
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
      {k_q, rn_q, wn_q, doff_q} <= 4'h7;
      {a_q, d_q, be_q, ra_q, wa_q, w0_q, w1_q} <= '0;
      {m0_q, m1_q} <= '1;
      {rp_q, wp_q, gap_q, wgo_q} <= 4'h0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      {k_q, rn_q, wn_q, doff_q} <= {k_d, rn_d, wn_d, dll_on};
      {a_q, d_q, be_q, ra_q, wa_q, w0_q, w1_q} <=
        {a_d, d_d, be_d, ra_d, wa_d, w0_d, w1_d};
      {m0_q, m1_q} <= {m0_d, m1_d};
      {rp_q, wp_q, gap_q, wgo_q} <= {rp_d, wp_d, gap_d, wgo_d};
    end
  end

  assign lnk.k = k_q;
  assign lnk.k_n = !k_q;
  assign lnk.read_n = rn_q;
  assign lnk.write_n = wn_q;
  assign lnk.doff_n = doff_q;
  assign lnk.sync_addr_in = a_q;
  assign lnk.write_data_in = d_q;
  assign lnk.byte_lane_write_n = be_q;
  assign rd_ready = !rp_q;
  assign wr_ready = !wp_q;

  ////////////////////////////////////////////////////////////////////////
  // Read capture on echo clock edges
  localparam int IW = 2 + DW;
  logic [IW-1:0] s1_q, s2_q, s3_q;
  logic e_lvl_q, e_lvl_d, vprev_q, vprev_d, got_q, got_d, done_d;
  logic [DW-1:0] q0_q, q0_d, q1_q, q1_d;
  logic done_q;

  always_comb begin
    {e_lvl_d, vprev_d, got_d, q0_d, q1_d} =
      {e_lvl_q, vprev_q, got_q, q0_q, q1_q};
    done_d = 1'b0;
    if (s2_q[IW-1] == s3_q[IW-1] && s3_q[IW-1] != e_lvl_q) begin
      e_lvl_d = s3_q[IW-1];
      vprev_d = s3_q[IW-2];
      if (got_q) begin
        q1_d = s3_q[DW-1:0];
        got_d = 1'b0;
        done_d = 1'b1;
      end else if (vprev_q) begin
        q0_d = s3_q[DW-1:0];
        got_d = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {s1_q, s2_q, s3_q} <= '0;
      {e_lvl_q, vprev_q, got_q, done_q} <= 4'h0;
      {q0_q, q1_q} <= '0;
    end else if (ce) begin
      s1_q <= {lnk.echo_timing_out, lnk.read_valid_flag, lnk.read_data_out};
      s2_q <= s1_q;
      s3_q <= s2_q;
      {e_lvl_q, vprev_q, got_q, done_q} <= {e_lvl_d, vprev_d, got_d, done_d};
      {q0_q, q1_q} <= {q0_d, q1_d};
    end
  end

  assign rd_done = done_q;
  assign rd_word0 = q0_q;
  assign rd_word1 = q1_q;
endmodule : bsp_host

// file: testbench/bsp_link_assertions.sv
// Timing checks on the link between the controller and the SRAM end
`timescale 1ns/100ps
module bsp_link_assertions (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic k,
  input wire logic read_n,
  input wire logic doff_n,
  input wire logic read_data_oe,
  input wire logic echo_timing_out,
  input wire logic echo_timing_out_bar,
  input wire logic read_valid_flag
);
  logic k_q;
  logic k_d;
  logic [127:0] rd_hist_q;
  logic [127:0] rd_hist_d;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////////////
  // History of read commands seen at link clock rises
  always_comb begin
    k_d = k;
    rd_hist_d = {rd_hist_q[126:0], k & ~k_q & ~read_n};
  end
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      k_q <= 1'b1;
      rd_hist_q <= '0;
    end else begin
      k_q <= k_d;
      rd_hist_q <= rd_hist_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  echo_follow_a: assert property ($rose(k) |-> ##[1:8] echo_timing_out)
    else $error("echo clock did not follow link clock");
  echo_pair_a: assert property (echo_timing_out != echo_timing_out_bar)
    else $error("echo pair not complementary");
  oe_cause_a: assert property (read_data_oe |-> (|rd_hist_q[89:14]))
    else $error("read data driven without a read");
  word0_edge_a: assert property (doff_n && $rose(read_data_oe) |-> $fell(echo_timing_out))
    else $error("first word not on complementary rise");
  dll_off_a: assert property (!doff_n && $rose(read_data_oe) |-> $rose(echo_timing_out))
    else $error("short latency word not on link rise");
  burst_hold_a: assert property ($rose(read_data_oe) |-> read_data_oe[*8] ##9 read_data_oe)
    else $error("burst cut short");
  burst_end_a: assert property ($rose(read_data_oe) |-> ##[19:21] !read_data_oe)
    else $error("burst not two words long");
  valid_lead_a: assert property ($rose(read_valid_flag) |-> !read_data_oe ##[9:11] read_data_oe)
    else $error("valid flag does not lead data");
  valid_drop_a: assert property ($rose(read_valid_flag) |-> ##[9:11] !read_valid_flag)
    else $error("valid flag not dropped before last word");
endmodule : bsp_link_assertions

// file: testbench/bsp_link_tb.sv
// Self-checking bench for both ends of the burst-of-two SRAM link
`timescale 1ns/100ps
module bsp_link_tb;
  typedef struct {
    logic [7:0] addr;
    logic [35:0] w0;
    logic [35:0] w1;
    logic [3:0] l0;
    logic [3:0] l1;
  } bsp_row_t;
  logic ref_clk;
  logic rstn;
  logic dll_on;
  logic rd_req;
  logic [bsp_pkg::ADDR_W-1:0] rd_addr;
  logic rd_ready;
  logic wr_req;
  logic [bsp_pkg::ADDR_W-1:0] wr_addr;
  logic [bsp_pkg::DATA_W-1:0] wr_word0;
  logic [bsp_pkg::DATA_W-1:0] wr_word1;
  logic [bsp_pkg::LANES-1:0] wr_lane0_n;
  logic [bsp_pkg::LANES-1:0] wr_lane1_n;
  logic wr_ready;
  logic rd_done;
  logic [bsp_pkg::DATA_W-1:0] rd_word0;
  logic [bsp_pkg::DATA_W-1:0] rd_word1;
  logic [bsp_pkg::IMP_W-1:0] imp_ref;
  logic [bsp_pkg::IMP_W-1:0] imp_code;
  logic [35:0] exp_mem [256];
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  bsp_row_t rows [4] = '{
    '{8'h10, 36'h1_2345_6789, 36'h9_8765_4321, 4'h0, 4'h0},
    '{8'hFF, 36'hA_5A5A_5A5A, 36'h5_A5A5_A5A5, 4'h0, 4'h0},
    '{8'h10, 36'hF_FFFF_FFFF, 36'h0_0000_0000, 4'h5, 4'hA},
    '{8'h10, 36'h0_0F0F_0F0F, 36'hF_0F0F_F0F0, 4'hF, 4'h3}};
  bsp_link_if u_bsp_link_if ();
  bsp_dev u_bsp_dev (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
    .lnk(u_bsp_link_if), .impedance_ref_pin(imp_ref),
    .drive_imp_code(imp_code));
  bsp_host u_bsp_host (.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1),
    .lnk(u_bsp_link_if), .dll_on(dll_on), .rd_req(rd_req),
    .rd_addr(rd_addr), .rd_ready(rd_ready), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_word0(wr_word0), .wr_lane0_n(wr_lane0_n),
    .wr_word1(wr_word1), .wr_lane1_n(wr_lane1_n), .wr_ready(wr_ready),
    .rd_done(rd_done), .rd_word0(rd_word0), .rd_word1(rd_word1));
  bsp_link_assertions u_chk (.ref_clk(ref_clk), .rstn(rstn),
    .k(u_bsp_link_if.k), .read_n(u_bsp_link_if.read_n),
    .doff_n(u_bsp_link_if.doff_n),
    .read_data_oe(u_bsp_link_if.read_data_oe),
    .echo_timing_out(u_bsp_link_if.echo_timing_out),
    .echo_timing_out_bar(u_bsp_link_if.echo_timing_out_bar),
    .read_valid_flag(u_bsp_link_if.read_valid_flag));
  ////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 50000) begin
      bad_count++;
      $display("MISMATCH t=%0t run too long", $time);
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // Compare tasks and byte lane merge
  task automatic check_word(input logic [35:0] got, input logic [35:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t word %h expected %h", $time, got, exp);
    end
  endtask : check_word
  task automatic check_code(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t code %h expected %h", $time, got, exp);
    end
  endtask : check_code
  function automatic logic [35:0] merge(input logic [35:0] o,
    input logic [35:0] n, input logic [3:0] l);
    for (int i = 0; i < 4; i++) begin
      if (!l[i]) o[9*i+:9] = n[9*i+:9];
    end
    return o;
  endfunction : merge
  ////////////////////////////////////////////////////////////////////////
  // User side transfers, started and ended at falling edges
  task automatic do_write(input bsp_row_t r);
    int n;
    n = 0;
    while (wr_ready !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    wr_req = 1'b1;
    wr_addr = r.addr;
    wr_word0 = r.w0;
    wr_word1 = r.w1;
    wr_lane0_n = r.l0;
    wr_lane1_n = r.l1;
    exp_mem[r.addr] = merge(exp_mem[r.addr], r.w0, r.l0);
    exp_mem[r.addr+8'd1] = merge(exp_mem[r.addr+8'd1], r.w1, r.l1);
    @(negedge ref_clk);
    wr_req = 1'b0;
  endtask : do_write
  task automatic do_read(input logic [7:0] a);
    int n;
    n = 0;
    while (rd_ready !== 1'b1 && n < 500) begin
      @(negedge ref_clk);
      n++;
    end
    rd_req = 1'b1;
    rd_addr = a;
    @(negedge ref_clk);
    rd_req = 1'b0;
    n = 0;
    while (rd_done !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    check_code({3'b0, rd_done}, 4'h1);
    check_word(rd_word0, exp_mem[a]);
    check_word(rd_word1, exp_mem[a+8'd1]);
  endtask : do_read
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rstn = 1'b0;
    dll_on = 1'b1;
    rd_req = 1'b0;
    rd_addr = '0;
    wr_req = 1'b0;
    wr_addr = '0;
    wr_word0 = '0;
    wr_word1 = '0;
    wr_lane0_n = '1;
    wr_lane1_n = '1;
    imp_ref = 4'h3;
    repeat (3) @(negedge ref_clk);
    check_code(imp_code, bsp_pkg::IMP_MID);
    check_code({3'b0, u_bsp_link_if.read_data_oe}, 4'h0);
    check_code({3'b0, u_bsp_link_if.echo_timing_out_bar}, 4'h1);
    rstn = 1'b1;
    foreach (rows[i]) begin
      do_write(rows[i]);
      do_read(rows[i].addr);
    end
    fork
      do_write(bsp_row_t'{8'h80, 36'h3_3333_3333, 36'hC_CCCC_CCCC,
        4'h0, 4'h0});
      do_read(rows[0].addr);
    join
    foreach (rows[i]) do_read(rows[i].addr);
    do_read(8'h80);
    dll_on = 1'b0;
    repeat (40) @(negedge ref_clk);
    do_read(rows[1].addr);
    dll_on = 1'b1;
    repeat (40) @(negedge ref_clk);
    repeat (20480) @(negedge ref_clk);
    check_code(imp_code, 4'h3);
    imp_ref = 4'hA;
    repeat (20480) @(negedge ref_clk);
    check_code(imp_code, 4'hA);
    tally_and_finish();
  end
endmodule : bsp_link_tb
